// [design/rtp_pkg.sv]
// Shared constants and types for the three-wire host port of the calendar clock
package rtp_pkg;

   // ***************************************************************
   // Serial framing
   // ***************************************************************
   localparam int unsigned CMD_BITS  = 8;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned BIT_CNT_W = 4;

   // ***************************************************************
   // Timebase
   // ***************************************************************
   localparam int unsigned CLK_HZ      = 250_000_000;
   localparam int unsigned TICK_HZ     = 32_768;
   localparam int unsigned TICK_DIV    = CLK_HZ / TICK_HZ;
   localparam int unsigned TICKS_SEC   = 32_768;
   localparam int unsigned SEC_MIN     = 60;
   localparam int unsigned HALF_MIN    = 30;
   localparam int unsigned LAST_YEAR   = 99;
   localparam int unsigned USER_DIV_W  = 15;

   // ***************************************************************
   // Interrupt source selection
   // ***************************************************************
   typedef enum logic [2:0] {
      RTP_SRC_OFF,
      RTP_SRC_ALARM1,
      RTP_SRC_ALARM2,
      RTP_SRC_USER_FREQ,
      RTP_SRC_MIN_PER1,
      RTP_SRC_MIN_PER2,
      RTP_SRC_TIMEBASE
   } rtp_src_t;

   localparam logic [2:0] SRC_RESET = 3'h0;

   // Register indices carried by the command byte
   localparam logic [3:0] REG_STATUS1 = 4'h0;
   localparam logic [3:0] REG_STATUS2 = 4'h1;
   localparam logic [3:0] REG_SECOND  = 4'h2;
   localparam logic [3:0] REG_MINUTE  = 4'h3;
   localparam logic [3:0] REG_HOUR    = 4'h4;
   localparam logic [3:0] REG_DAY     = 4'h5;
   localparam logic [3:0] REG_MONTH   = 4'h6;
   localparam logic [3:0] REG_YEAR    = 4'h7;
   localparam logic [3:0] REG_ALARM1  = 4'h8;
   localparam logic [3:0] REG_ALARM2  = 4'h9;
   localparam logic [3:0] REG_USERDIV = 4'hA;
   localparam int unsigned CMD_READ_BIT = 7;

   // Status register 1 field: power-fail flag
   localparam int unsigned ST1_POWER_FLAG = 0;

   typedef struct packed {
      logic [6:0] minute;
      logic [4:0] hour;
      logic [4:0] day;
      logic [3:0] month;
      logic [6:0] year;
   } rtp_cal_t;

   typedef struct packed {
      logic o;
      logic oe;
   } rtp_od_t;

endpackage : rtp_pkg

// [design/rtp_calendar.sv]
// Calendar counter driven by the 32.768 kHz tick enable
`timescale 1ns/10ps
`default_nettype none
module rtp_calendar
   import rtp_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          tick_i,
   input  wire logic          wr_i,
   input  wire logic [3:0]    wr_reg_i,
   input  wire logic [7:0]    wr_data_i,
   output logic               sec_pulse_o,
   output logic [5:0]         second_o,
   output rtp_pkg::rtp_cal_t  cal_o
);
   logic [14:0] sub;
   logic [4:0]  last_day;
   logic        leap;
   logic        sec_end;

   // Every year divisible by four is leap inside the 2000-2099 span
   assign leap    = (cal_o.year[1:0] == 2'h0);
   assign sec_end = tick_i && (sub == 15'(TICKS_SEC - 1));
   always_comb begin
      unique case (cal_o.month)
         4'h2:    last_day = leap ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: last_day = 5'h1E;
         default: last_day = 5'h1F;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sub         <= 15'h0000;
         second_o    <= 6'h00;
         sec_pulse_o <= 1'b0;
         cal_o       <= '{7'h00, 5'h00, 5'h01, 4'h1, 7'h00};
      end else begin
         sec_pulse_o <= sec_end;
         if (tick_i) sub <= sub + 15'h0001;
         if (wr_i) begin
            unique case (wr_reg_i)
               REG_SECOND: second_o   <= wr_data_i[5:0];
               REG_MINUTE: cal_o.minute <= wr_data_i[6:0];
               REG_HOUR:   cal_o.hour <= wr_data_i[4:0];
               REG_DAY:    cal_o.day  <= wr_data_i[4:0];
               REG_MONTH:  cal_o.month <= wr_data_i[3:0];
               REG_YEAR:   cal_o.year <= wr_data_i[6:0];
               default: ;
            endcase
         end else if (sec_end) begin
            second_o <= second_o + 6'h01;
            if (second_o == 6'(SEC_MIN - 1)) begin
               second_o <= 6'h00;
               cal_o.minute <= cal_o.minute + 7'h01;
               if (cal_o.minute == 7'h3B) begin
                  cal_o.minute <= 7'h00;
                  cal_o.hour <= cal_o.hour + 5'h01;
                  if (cal_o.hour == 5'h17) begin
                     cal_o.hour <= 5'h00;
                     cal_o.day  <= cal_o.day + 5'h01;
                     if (cal_o.day == last_day) begin
                        cal_o.day   <= 5'h01;
                        cal_o.month <= cal_o.month + 4'h1;
                        if (cal_o.month == 4'hC) begin
                           cal_o.month <= 4'h1;
                           cal_o.year  <= (cal_o.year == 7'(LAST_YEAR))
                                          ? 7'h00 : cal_o.year + 7'h01;
                        end
                     end
                  end
               end
            end
         end
      end
   end
endmodule : rtp_calendar
`default_nettype wire

// [design/rtp_host_port.sv]
// Three-wire serial host port, interrupt pin and timebase of the clock
`timescale 1ns/10ps
`default_nettype none
module rtp_host_port
   import rtp_pkg::*;
#(
   parameter int unsigned TICK_DIVIDE = TICK_DIV
)(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic chip_sel_i,
   input  wire logic serial_clk_i,
   input  wire logic serial_data_i,
   input  wire logic low_supply_i,
   output logic      serial_data_o,
   output logic      serial_data_oe_o,
   output logic      int_o,
   output logic      int_oe_o
);
   import rtp_pkg::*;

   initial begin
      // The divider counter is 16 bits wide
      if (TICK_DIVIDE < 2 || TICK_DIVIDE > 65536)
         $error("TICK_DIVIDE out of range");
   end

   // ***************************************************************
   // Timebase tick: stands in for the crystal divider
   // ***************************************************************
   logic [15:0] div_cnt;
   logic        tick;
   logic        tb_phase;
   wire         div_end = (div_cnt == 16'(TICK_DIVIDE - 1));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt  <= 16'h0000;
         tick     <= 1'b0;
         tb_phase <= 1'b0;
      end else begin
         div_cnt <= div_end ? 16'h0000 : div_cnt + 16'h0001;
         tick    <= div_end;
         if (div_end) tb_phase <= ~tb_phase;
      end
   end

   // ***************************************************************
   // Serial shifter
   // ***************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_WRITE, ST_READ} st_t;
   st_t            state;
   logic           sclk_q;
   logic [7:0]     shreg;
   logic [3:0]     bitcnt;
   logic [3:0]     reg_idx;
   logic           wr_stb;
   logic [7:0]     wr_byte;
   logic [7:0]     rd_byte;

   // Chip select gates the edge detector, so clock noise never counts
   wire rise   = chip_sel_i && serial_clk_i && !sclk_q;
   wire last   = (bitcnt == 4'(CMD_BITS - 1));
   wire [7:0] in_byte = {shreg[6:0], serial_data_i};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state   <= ST_IDLE;
         sclk_q  <= 1'b0;
         shreg   <= 8'h00;
         bitcnt  <= 4'h0;
         reg_idx <= 4'h0;
         wr_stb  <= 1'b0;
         wr_byte <= 8'h00;
      end else begin
         sclk_q <= serial_clk_i;
         wr_stb <= 1'b0;
         if (!chip_sel_i) begin
            state  <= ST_IDLE;
            bitcnt <= 4'h0;
         end else begin
            unique case (state)
               ST_IDLE: begin
                  state  <= ST_CMD;
                  bitcnt <= 4'h0;
               end
               ST_CMD: if (rise) begin
                  shreg  <= in_byte;
                  bitcnt <= last ? 4'h0 : bitcnt + 4'h1;
                  if (last) begin
                     reg_idx <= in_byte[3:0];
                     state   <= in_byte[CMD_READ_BIT] ? ST_READ : ST_WRITE;
                  end
               end
               ST_WRITE: if (rise) begin
                  shreg  <= in_byte;
                  bitcnt <= last ? 4'h0 : bitcnt + 4'h1;
                  if (last) begin
                     wr_stb  <= 1'b1;
                     wr_byte <= in_byte;
                     reg_idx <= reg_idx + 4'h1;
                  end
               end
               // Advance on the rise: the host samples the bit before it
               ST_READ: if (rise) begin
                  bitcnt <= last ? 4'h0 : bitcnt + 4'h1;
                  if (last) reg_idx <= reg_idx + 4'h1;
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ***************************************************************
   // Status, alarms and user frequency
   // ***************************************************************
   logic [7:0] status1;
   logic [2:0] int_src;
   logic [6:0] alarm1;
   logic [6:0] alarm2;
   logic [USER_DIV_W-1:0] user_div;
   logic [USER_DIV_W-1:0] user_cnt;
   logic       user_wave;
   logic       sec_pulse;
   logic [5:0] second;
   rtp_cal_t   cal;
   logic       pwr_seen;

   rtp_calendar u_cal (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .tick_i      (tick),
      .wr_i        (wr_stb),
      .wr_reg_i    (reg_idx - 4'h1),
      .wr_data_i   (wr_byte),
      .sec_pulse_o (sec_pulse),
      .second_o    (second),
      .cal_o       (cal)
   );

   wire wr_status1 = wr_stb && (reg_idx - 4'h1 == REG_STATUS1);
   wire wr_status2 = wr_stb && (reg_idx - 4'h1 == REG_STATUS2);
   wire low_sup_ev = low_supply_i || !pwr_seen;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status1  <= 8'h00;
         pwr_seen <= 1'b0;
         int_src  <= SRC_RESET;
         alarm1   <= 7'h00;
         alarm2   <= 7'h00;
         user_div <= '0;
         user_cnt <= '0;
         user_wave <= 1'b0;
      end else begin
         pwr_seen <= 1'b1;
         // A new low-supply event beats a host clear in the same cycle
         if (wr_status1) status1 <= wr_byte;
         if (low_sup_ev) status1[ST1_POWER_FLAG] <= 1'b1;
         if (wr_status2) int_src <= wr_byte[2:0];
         if (wr_stb && reg_idx - 4'h1 == REG_ALARM1) alarm1 <= wr_byte[6:0];
         if (wr_stb && reg_idx - 4'h1 == REG_ALARM2) alarm2 <= wr_byte[6:0];
         if (wr_stb && reg_idx - 4'h1 == REG_USERDIV)
            user_div <= {wr_byte[6:0], 8'h00};
         if (tick) begin
            user_cnt <= (user_cnt >= user_div) ? '0 : user_cnt + 1'b1;
            if (user_cnt >= user_div) user_wave <= ~user_wave;
         end
      end
   end

   // Read data selection
   always_comb begin
      unique case (reg_idx)
         REG_STATUS1: rd_byte = status1;
         REG_STATUS2: rd_byte = {5'h00, int_src};
         REG_SECOND:  rd_byte = {2'h0, second};
         REG_MINUTE:  rd_byte = {1'b0, cal.minute};
         REG_HOUR:    rd_byte = {3'h0, cal.hour};
         REG_DAY:     rd_byte = {3'h0, cal.day};
         REG_MONTH:   rd_byte = {4'h0, cal.month};
         REG_YEAR:    rd_byte = {1'b0, cal.year};
         default:     rd_byte = 8'h00;
      endcase
   end

   // ***************************************************************
   // Pin drivers
   // ***************************************************************
   wire a1_hit  = (cal.minute == alarm1) && (second == 6'h00);
   wire a2_hit  = (cal.minute == alarm2) && (second == 6'h00);
   wire min_hit = (second == 6'h00);
   wire half_lo = (second < 6'(HALF_MIN));
   logic int_active;

   always_comb begin
      unique case (int_src)
         3'(RTP_SRC_ALARM1):    int_active = a1_hit;
         3'(RTP_SRC_ALARM2):    int_active = a2_hit;
         3'(RTP_SRC_USER_FREQ): int_active = user_wave;
         3'(RTP_SRC_MIN_PER1):  int_active = min_hit;
         3'(RTP_SRC_MIN_PER2):  int_active = half_lo;
         3'(RTP_SRC_TIMEBASE):  int_active = tb_phase;
         default:               int_active = 1'b0;
      endcase
   end

   wire rd_bit = rd_byte[3'(CMD_BITS - 1) - bitcnt[2:0]];
   wire drive_low = chip_sel_i && (state == ST_READ) && !rd_bit;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_data_o    <= 1'b0;
         serial_data_oe_o <= 1'b0;
         int_o            <= 1'b0;
         int_oe_o         <= 1'b0;
      end else begin
         serial_data_o    <= 1'b0;
         serial_data_oe_o <= drive_low;
         int_o            <= 1'b0;
         int_oe_o         <= int_active;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   chk_deselect_release: assert property (@(posedge clk_i) disable iff (rst_i)
      !chip_sel_i |=> !serial_data_oe_o) else $error("data driven unselected");
   chk_select_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !chip_sel_i |=> state == ST_IDLE) else $error("state not idle");
   chk_edge_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      !chip_sel_i |=> bitcnt == 4'h0) else $error("bit counted unselected");
   chk_select_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(chip_sel_i) |=> state == ST_CMD) else $error("no command phase");
   chk_bit_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_CMD && rise && bitcnt == 4'h0) |=> bitcnt == 4'h1)
      else $error("bit not counted");
   chk_pull_low: assert property (@(posedge clk_i) disable iff (rst_i)
      serial_data_o == 1'b0 && int_o == 1'b0) else $error("pin driven high");
   chk_int_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      int_active |=> int_oe_o) else $error("interrupt not driven");
   chk_power_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      low_supply_i |=> status1[ST1_POWER_FLAG]) else $error("flag missing");
   chk_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
      tick |=> !tick) else $error("tick too wide");
endmodule : rtp_host_port
`default_nettype wire

// [bench/rtp_host_model.sv]
// Host processor model that drives the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
module rtp_host_model (
   input  wire logic clk_i,
   input  wire logic line_i,
   output var  logic cs_o,
   output var  logic sclk_o,
   output var  logic pull_low_o
);
   // ***************************************************************
   // Idle state
   // ***************************************************************
   initial begin
      cs_o       = 1'b0;
      sclk_o     = 1'b0;
      pull_low_o = 1'b0;
   end

   task automatic clk_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask : clk_n

   // ***************************************************************
   // One bit: data set up while the serial clock is low, line sampled
   // just before the rise, then the clock held high
   // ***************************************************************
   task automatic bit_io(input logic b, output logic s);
      sclk_o     <= 1'b0;
      pull_low_o <= ~b;
      clk_n(3);
      s = line_i;
      sclk_o <= 1'b1;
      clk_n(3);
   endtask : bit_io

   // Command byte then one data byte; sel low shows a deselected attempt
   task automatic xfer(input logic sel, input logic [7:0] cmd,
                       input logic [7:0] wd, output logic [7:0] rd);
      logic s;
      cs_o <= sel;
      clk_n(2);
      for (int i = 7; i >= 0; i--) begin
         bit_io(cmd[i], s);
      end
      for (int i = 7; i >= 0; i--) begin
         // Line released on reads so the port can pull it low
         bit_io(cmd[7] ? 1'b1 : wd[i], s);
         rd[i] = s;
      end
      pull_low_o <= 1'b0;
      cs_o       <= 1'b0;
      clk_n(2);
      sclk_o <= 1'b0;
      clk_n(3);
   endtask : xfer
endmodule : rtp_host_model
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the three-wire host port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import rtp_pkg::*;
   localparam int unsigned TDIV = 4;

   logic       clk_i;
   logic       rst_i;
   logic       low_supply_i;
   wire  logic cs;
   wire  logic sclk;
   wire  logic host_low;
   wire  logic sd_line;
   logic       sdo;
   logic       sdo_oe;
   logic       int_q;
   logic       int_oe;
   logic       cs_q;
   logic       cs_qq;
   logic       idle_drive = 1'b0;
   logic [7:0] rd;
   int         err_count;
   int         tests_run;

   // Open-drain data line with pull-up
   assign sd_line = ~((sdo_oe & ~sdo) | host_low);

   rtp_host_port #(.TICK_DIVIDE(TDIV)) DUT (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .chip_sel_i      (cs),
      .serial_clk_i    (sclk),
      .serial_data_i   (sd_line),
      .low_supply_i    (low_supply_i),
      .serial_data_o   (sdo),
      .serial_data_oe_o(sdo_oe),
      .int_o           (int_q),
      .int_oe_o        (int_oe)
   );

   rtp_host_model u_host (
      .clk_i     (clk_i),
      .line_i    (sd_line),
      .cs_o      (cs),
      .sclk_o    (sclk),
      .pull_low_o(host_low)
   );

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Release is allowed two clocks after select falls
   always @(posedge clk_i) begin
      cs_q  <= cs;
      cs_qq <= cs_q;
      if (!rst_i && !cs && !cs_q && !cs_qq && sdo_oe === 1'b1) begin
         idle_drive <= 1'b1;
      end
   end

   // ***************************************************************
   // Shared checks
   // ***************************************************************
   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check

   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   task automatic wr(input logic [3:0] r, input logic [7:0] d);
      u_host.xfer(1'b1, {4'h0, r}, d, rd);
   endtask : wr

   task automatic rdreg(input logic [3:0] r);
      u_host.xfer(1'b1, {4'h8, r}, 8'h00, rd);
   endtask : rdreg

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic sc_reset;
      check("data oe after reset", 8'h00, {7'h00, sdo_oe});
      check("int oe after reset", 8'h00, {7'h00, int_oe});
   endtask : sc_reset

   task automatic sc_power_flag;
      rdreg(REG_STATUS1);
      check("power flag at start", 8'h01, rd & 8'h01);
   endtask : sc_power_flag

   task automatic sc_deselect;
      u_host.xfer(1'b0, {4'h0, REG_STATUS2}, 8'h06, rd);
      rdreg(REG_STATUS2);
      check("source after deselected write", 8'h00, rd & 8'h07);
      check("int oe source off", 8'h00, {7'h00, int_oe});
   endtask : sc_deselect

   task automatic sc_sources;
      int   rises;
      logic prev;
      rises = 0;
      prev  = 1'b0;
      for (int k = 1; k <= 6; k++) begin
         wr(REG_STATUS2, 8'(k));
         rdreg(REG_STATUS2);
         check("source readback", 8'(k), rd & 8'h07);
      end
      // Timebase source: the pin must pulse, not sit at one level
      repeat (200) begin
         @(negedge clk_i);
         if (int_oe === 1'b1 && prev === 1'b0) rises++;
         prev = int_oe;
      end
      check("timebase pulses", 8'h01, {7'h00, rises > 0});
      check("int drive level", 8'h00, {7'h00, int_q});
      wr(REG_STATUS2, 8'h00);
      repeat (20) @(posedge clk_i);
      check("int released when off", 8'h00, {7'h00, int_oe});
   endtask : sc_sources

   task automatic sc_low_supply;
      wr(REG_STATUS1, 8'h00);
      rdreg(REG_STATUS1);
      check("power flag cleared", 8'h00, rd & 8'h01);
      low_supply_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      low_supply_i <= 1'b0;
      rdreg(REG_STATUS1);
      check("power flag on low supply", 8'h01, rd & 8'h01);
      check("data drive level", 8'h00, {7'h00, sdo});
      check("no drive while idle", 8'h00, {7'h00, idle_drive});
   endtask : sc_low_supply

   // ***************************************************************
   // Main sequence and watchdog
   // ***************************************************************
   initial begin
      rst_i        = 1'b1;
      low_supply_i = 1'b0;
      err_count    = 0;
      tests_run    = 0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      sc_reset();
      sc_power_flag();
      sc_deselect();
      sc_sources();
      sc_low_supply();
      final_report();
   end

   initial begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      final_report();
   end
endmodule : tb_top
`default_nettype wire
